//--- src/jog_ctrl_regs.vh
// register map, field positions, reset values and timing counts of the jog controller
`ifndef JOG_CTRL_REGS_VH
`define JOG_CTRL_REGS_VH

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_CMD_VEL    8'h08
`define OFS_TIMEBASE   8'h0c
`define OFS_VEL0       8'h10
`define OFS_VEL1       8'h14
`define OFS_ACC0       8'h18
`define OFS_ACC1       8'h1c
`define OFS_DEC0       8'h20
`define OFS_DEC1       8'h24
`define OFS_STOP_DEC   8'h28

`define CTRL_SET_SEL   0
`define CTRL_POS_HOLD  1
`define CTRL_NEG_HOLD  2
`define CTRL_MOVE_HOLD 3
`define CTRL_HALT      4
`define CTRL_POS0      8
`define CTRL_NEG0      9
`define CTRL_POS1      10
`define CTRL_NEG1      11

`define ST_ACCEL       0
`define ST_AT_SPEED    1
`define ST_DECEL       2
`define ST_ACTIVE      3
`define ST_DONE        4
`define ST_JOG1_BASE   8
`define ST_ANY_DONE    16
`define ST_HALTING     17
`define ST_HOLD_STOP   18

`define RST_VEL        32'h0000_1000
`define RST_ACC        32'h0000_0010
`define RST_STOP_DEC   32'h0000_0040

`define CLK_PERIOD_NS  25
`define RT_TICK_NS     1000
`define RT_TICK_CYC    ((`RT_TICK_NS) / (`CLK_PERIOD_NS))

`endif

//--- src/dual_jog_profile_controller.v
// two-set jog profile generator with an avalon-mm register slave
//
// Notes on behaviour
// R1 - select level picks set zero or one
// R2 - select change ramps between set velocities
// R3 - halt command decelerates at active decel
// R4 - each set has own accel, decel
// R5 - accelerating flag until target reached
// R6 - at-speed set at target, cleared on ramp
// R7 - done at zero speed until restarted
// R8 - active from ramp start to stop
// R9 - decelerating flag throughout deceleration ramp
// R10 - negative start bit jogs negative
// R11 - positive start bit jogs positive
// R12 - per-set real-time or sync time base
// R13 - same set velocity for both request kinds
// R14 - hold level blocks all motion
// R15 - motion statement stalls while hold asserted
// R16 - hold stops at stop decel, real-time
// R17 - hold requests run while held, stop after
// R18 - shared done flag, cleared on new jog
// R19 - both directions together decelerate to zero; opposite start bits of the two sets jog in the set-1 direction
// R20 - hold ignores starts; done at zero only
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`include "jog_ctrl_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module dual_jog_profile_controller #(
  parameter VW     = 24,
  parameter RT_CYC = `RT_TICK_CYC
) (
  input  wire          i_ref_clk,
  input  wire          i_resetn,
  input  wire [7:0]    i_address,
  input  wire          i_read,
  input  wire          i_write,
  input  wire [31:0]   i_writedata,
  output reg  [31:0]   o_readdata,
  output wire          o_waitrequest,
  input  wire          i_sync_tick,
  input  wire          i_prog_move_req,
  output wire          o_prog_stall,
  output reg  [VW-1:0] o_cmd_vel
);

  reg          ack;
  reg  [31:0]  ctrl;
  reg  [1:0]   timebase;
  reg  [VW-1:0] vel [0:1];
  reg  [VW-1:0] acc [0:1];
  reg  [VW-1:0] dec [0:1];
  reg  [VW-1:0] stop_dec;
  reg          halting;
  reg          running;
  reg          owner;
  wire [1:0]   done;
  reg          any_done;
  reg  [15:0]  rt_cnt;
  reg          rt_tick;
  reg  signed [VW-1:0] tgt;

  // reset values and the real-time divider end point, cut to the widths they meet
  localparam [31:0] VEL_INIT  = `RST_VEL;
  localparam [31:0] RATE_INIT = `RST_ACC;
  localparam [31:0] STOP_INIT = `RST_STOP_DEC;
  localparam [31:0] RT_FULL   = RT_CYC;
  localparam [15:0] RT_LAST   = RT_FULL[15:0] - 16'h0001;

  wire signed [VW-1:0] cmd = o_cmd_vel;
  wire         access = (i_read | i_write) & ~ack;
  wire         wr = i_write & ack;

  // one wait state: every access completes on the second edge
  assign o_waitrequest = (i_read | i_write) & ~ack;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  wire move_hold = ctrl[`CTRL_MOVE_HOLD];
  assign o_prog_stall = move_hold & i_prog_move_req; // R15

  // an explicit start bit names its own set, otherwise the select level decides
  wire start1 = ctrl[`CTRL_POS1] | ctrl[`CTRL_NEG1];
  wire start0 = ctrl[`CTRL_POS0] | ctrl[`CTRL_NEG0];
  wire use_set = start1 ? 1'b1 : (start0 ? 1'b0 : ctrl[`CTRL_SET_SEL]); // R1
  wire want_pos = ctrl[`CTRL_POS_HOLD] | (use_set ? ctrl[`CTRL_POS1] : ctrl[`CTRL_POS0]); // R11 R17
  wire want_neg = ctrl[`CTRL_NEG_HOLD] | (use_set ? ctrl[`CTRL_NEG1] : ctrl[`CTRL_NEG0]); // R10 R17
  wire any_req = want_pos | want_neg;
  wire signed [VW-1:0] set_vel = vel[use_set]; // R13

  reg signed [VW-1:0] next_tgt;
  always @* begin
    next_tgt = {VW{1'b0}};
    if (move_hold || halting) begin
      next_tgt = {VW{1'b0}}; // R3 R14
    end else if (want_pos && want_neg) begin
      next_tgt = {VW{1'b0}}; // R19
    end else if (want_pos && (running || !move_hold)) begin
      next_tgt = set_vel; // R11 R2
    end else if (want_neg) begin
      next_tgt = -set_vel; // R10 R2
    end
  end

  // real-time base; the hold stop always uses it whatever the set's base
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rt_cnt  <= 16'h0000;
      rt_tick <= 1'b0;
    end else if (rt_cnt == RT_LAST) begin
      rt_cnt  <= 16'h0000;
      rt_tick <= 1'b1;
    end else begin
      rt_cnt  <= rt_cnt + 16'h0001;
      rt_tick <= 1'b0;
    end
  end

  wire tick = move_hold ? rt_tick : (timebase[use_set] ? i_sync_tick : rt_tick); // R12 R16

  // direction of step and whether magnitude is growing
  wire         go_up   = cmd < tgt;
  wire         go_dn   = cmd > tgt;
  wire         growing = go_up ? (cmd >= 0) : (cmd <= 0);
  wire [VW-1:0] rate   = move_hold ? stop_dec : (growing ? acc[use_set] : dec[use_set]); // R4 R16 R3
  // never step past zero while reversing, so decel and accel use their own rates
  wire signed [VW-1:0] limit = ((cmd < 0 && tgt > 0) || (cmd > 0 && tgt < 0)) ? {VW{1'b0}} : tgt;
  wire signed [VW:0] up_sum = {cmd[VW-1], cmd} + {1'b0, rate};
  wire signed [VW:0] dn_sum = {cmd[VW-1], cmd} - {1'b0, rate};
  wire signed [VW:0] lim_x  = {limit[VW-1], limit};

  reg signed [VW-1:0] next_cmd;
  always @* begin
    next_cmd = cmd;
    if (tick && running && go_up) begin
      next_cmd = (up_sum > lim_x) ? limit : up_sum[VW-1:0];
    end else if (tick && running && go_dn) begin
      next_cmd = (dn_sum < lim_x) ? limit : dn_sum[VW-1:0];
    end
  end

  wire start_now = !running && !move_hold && !halting && (next_tgt != 0); // R20
  wire finish    = running && (cmd == 0) && (tgt == 0) && !start_now;

  // target lags the control word by one edge; velocity follows the target
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cmd_vel <= {VW{1'b0}};
      tgt       <= {VW{1'b0}};
    end else begin
      tgt       <= next_tgt;
      o_cmd_vel <= next_cmd;
    end
  end

  // halt is a one-cycle write, so it is latched until the axis is at rest
  // and no request is left; otherwise a held request would restart at once
  wire halt_wr = wr && (i_address == `OFS_CTRL) && i_writedata[`CTRL_HALT];

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      halting <= 1'b0;
    end else if (halt_wr) begin
      halting <= 1'b1; // R3
    end else if (!running && !any_req) begin
      halting <= 1'b0;
    end
  end

  // one profile at a time; the set that started it owns its status
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      running <= 1'b0;
      owner   <= 1'b0;
    end else if (start_now) begin
      running <= 1'b1; // R8
      owner   <= use_set;
    end else if (finish) begin
      running <= 1'b0; // R8
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      any_done <= 1'b0;
    end else if (start_now) begin
      any_done <= 1'b0; // R18
    end else if (finish) begin
      any_done <= 1'b1; // R18
    end
  end

  // per-set done flag and status word
  wire [4:0] st_set [0:1];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_set
      reg set_done;
      always @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          set_done <= 1'b0;
        end else if (start_now && (use_set == g)) begin
          set_done <= 1'b0; // R7
        end else if (finish && (owner == g)) begin
          set_done <= 1'b1; // R7 R20
        end
      end
      assign done[g]   = set_done;
      assign st_set[g] = ((owner == g) ? st_own : 5'h00) | {set_done, 4'h0};
    end
  endgenerate

  // per-jog status, owned by the set that started the motion
  wire moving_on = running && (cmd != tgt);
  wire st_accel  = moving_on && (cmd == 0 ? tgt != 0 : growing); // R5
  wire st_decel  = moving_on && !st_accel; // R9
  wire st_at     = running && (cmd == tgt) && (tgt != 0); // R6
  wire [4:0] st_own = {1'b0, running, st_decel, st_at, st_accel};
  wire [4:0] st0       = st_set[0];
  wire [4:0] st1       = st_set[1];
  // a stop forced by the hold is shown apart from a halt command
  wire       hold_stop = move_hold && running; // R16
  wire [31:0] status = {13'h0000, hold_stop, halting, any_done,
                        3'h0, st1, 3'h0, st0};

  // registers; the halt bit is a write-only pulse and reads zero
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl     <= 32'h0000_0000;
      timebase <= 2'b00;
      vel[0]   <= VEL_INIT[VW-1:0];
      vel[1]   <= VEL_INIT[VW-1:0];
      acc[0]   <= RATE_INIT[VW-1:0];
      acc[1]   <= RATE_INIT[VW-1:0];
      dec[0]   <= RATE_INIT[VW-1:0];
      dec[1]   <= RATE_INIT[VW-1:0];
      stop_dec <= STOP_INIT[VW-1:0];
    end else if (wr) begin
      case (i_address)
        `OFS_CTRL:     ctrl     <= i_writedata & 32'h0000_0f0f;
        `OFS_TIMEBASE: timebase <= i_writedata[1:0];
        `OFS_VEL0:     vel[0]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_VEL1:     vel[1]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_ACC0:     acc[0]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_ACC1:     acc[1]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_DEC0:     dec[0]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_DEC1:     dec[1]   <= {1'b0, i_writedata[VW-2:0]};
        `OFS_STOP_DEC: stop_dec <= {1'b0, i_writedata[VW-2:0]};
        default:       ctrl     <= ctrl;
      endcase
    end
  end

  reg [31:0] next_rd;
  always @* begin
    case (i_address)
      `OFS_CTRL:     next_rd = ctrl;
      `OFS_STATUS:   next_rd = status;
      `OFS_CMD_VEL:  next_rd = {{(32-VW){cmd[VW-1]}}, cmd};
      `OFS_TIMEBASE: next_rd = {30'h0000_0000, timebase};
      `OFS_VEL0:     next_rd = {{(32-VW){1'b0}}, vel[0]};
      `OFS_VEL1:     next_rd = {{(32-VW){1'b0}}, vel[1]};
      `OFS_ACC0:     next_rd = {{(32-VW){1'b0}}, acc[0]};
      `OFS_ACC1:     next_rd = {{(32-VW){1'b0}}, acc[1]};
      `OFS_DEC0:     next_rd = {{(32-VW){1'b0}}, dec[0]};
      `OFS_DEC1:     next_rd = {{(32-VW){1'b0}}, dec[1]};
      `OFS_STOP_DEC: next_rd = {{(32-VW){1'b0}}, stop_dec};
      default:       next_rd = 32'h0000_0000;
    endcase
  end

  // read data sampled on the waited cycle, valid at the edge waitrequest drops
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_readdata <= 32'h0000_0000;
    end else if (access && i_read) begin
      o_readdata <= next_rd;
    end
  end

endmodule

`default_nettype wire

//--- tb/jog_chk_asserts.sv
// port-level assertions for the jog controller
`timescale 1ns/10ps
`default_nettype none
module jog_chk #(parameter VW = 24) (
  input wire logic          i_ref_clk,
  input wire logic          i_resetn,
  input wire logic [7:0]    i_address,
  input wire logic          i_read,
  input wire logic          i_write,
  input wire logic [31:0]   i_writedata,
  input wire logic [31:0]   o_readdata,
  input wire logic          o_waitrequest,
  input wire logic          i_sync_tick,
  input wire logic          i_prog_move_req,
  input wire logic          o_prog_stall,
  input wire logic [VW-1:0] o_cmd_vel
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire rq = i_read | i_write;
  chk_wait_first: assert property (rq && !$past(rq) |-> o_waitrequest)
    else $error("access finished without a wait state");
  chk_wait_one: assert property (rq && o_waitrequest |=> !o_waitrequest)
    else $error("more than one wait state");
  chk_wait_idle: assert property (!rq |-> !o_waitrequest)
    else $error("wait state with no access");
  chk_rdata_hold: assert property (!i_read |=> $stable(o_readdata))
    else $error("read data moved without a read");
  chk_vel_reset: assert property ($rose(i_resetn) |-> o_cmd_vel == '0)
    else $error("velocity not zero after reset");
  chk_stall_req: assert property (o_prog_stall |-> i_prog_move_req)
    else $error("stall without a motion statement");
  chk_vel_gap: assert property ($changed(o_cmd_vel) |=> $stable(o_cmd_vel))
    else $error("velocity stepped on two edges in a row");
  chk_vel_sign: assert property ($changed(o_cmd_vel[VW-1]) |->
      ($past(o_cmd_vel) == '0 || o_cmd_vel == '0))
    else $error("direction flipped without passing zero");
endmodule
`default_nettype wire

//--- tb/jog_prog_model.sv
// program-side model: external sync pulses and the motion-statement level
`timescale 1ns/10ps
`default_nettype none
module jog_prog_model (
  input wire logic i_ref_clk,
  input wire logic i_tick_en,
  input wire logic i_move,
  output var logic o_sync_tick,
  output var logic o_move_req
);
  logic [2:0] cnt = 3'h0;
  initial o_sync_tick = 1'b0;
  initial o_move_req = 1'b0;
  // slow sync rate, so real-time and synchronized ramps differ visibly
  always @(posedge i_ref_clk) begin
    cnt <= cnt + 3'h1;
    o_sync_tick <= i_tick_en && cnt == 3'h7;
    o_move_req <= i_move;
  end
endmodule
`default_nettype wire

//--- tb/dual_jog_profile_controller_tb.sv
// self-checking bench for the jog controller
`include "jog_ctrl_regs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module dual_jog_profile_controller_tb;
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_read = 1'b0, i_write = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic [31:0] i_writedata = 32'h0, o_readdata, q;
  logic o_waitrequest, i_sync_tick, i_prog_move_req, o_prog_stall, tick_en = 1'b0, mv = 1'b0;
  logic [23:0] o_cmd_vel;
  int errors = 0, n_compared = 0;
  logic [7:0] ra[12] = '{`OFS_CTRL, `OFS_STATUS, `OFS_CMD_VEL, `OFS_TIMEBASE, `OFS_VEL0,
    `OFS_VEL1, `OFS_ACC0, `OFS_ACC1, `OFS_DEC0, `OFS_DEC1, `OFS_STOP_DEC, 8'h30};
  logic [31:0] rv[12] = '{0, 0, 0, 0, `RST_VEL, `RST_VEL, `RST_ACC, `RST_ACC, `RST_ACC,
    `RST_ACC, `RST_STOP_DEC, 0};
  dual_jog_profile_controller #(.RT_CYC(4)) u_dut (.i_ref_clk, .i_resetn, .i_address,
    .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_sync_tick,
    .i_prog_move_req, .o_prog_stall, .o_cmd_vel);
  jog_prog_model u_prog (.i_ref_clk, .i_tick_en(tick_en), .i_move(mv),
    .o_sync_tick(i_sync_tick), .o_move_req(i_prog_move_req));
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  // request held until a rising edge samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_address <= a; i_writedata <= d; i_read <= !w; i_write <= w;
    do begin @(posedge i_ref_clk); n++; end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = o_readdata;
    i_read <= 1'b0; i_write <= 1'b0;
  endtask
  task automatic waitv(input logic [31:0] e);
    int n;
    n = 0;
    do begin bus(0, `OFS_CMD_VEL, 0); n++; end while (q !== e && n < 400);
    `CHK(q, e)
  endtask
  task automatic stop_test;
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin repeat (20000) @(posedge i_ref_clk); errors++; stop_test; end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin bus(0, ra[i], 0); `CHK(q, rv[i]) end
    bus(1, `OFS_VEL0, 32'h40); bus(1, `OFS_VEL1, 32'h80);
    bus(1, `OFS_CTRL, 32'h100); waitv(32'h40);
    bus(0, `OFS_STATUS, 0); `CHK(q[4:0], 5'h0a)
    bus(1, `OFS_CTRL, 0); bus(0, `OFS_STATUS, 0); `CHK(q[4:0], 5'h0c)
    waitv(0); bus(0, `OFS_STATUS, 0); `CHK(q, 32'h0001_0010)
    bus(1, `OFS_CTRL, 32'h200); waitv(32'hffff_ffc0);
    bus(1, `OFS_CTRL, 32'h100); waitv(32'h40);
    bus(1, `OFS_CTRL, 32'h2); bus(1, `OFS_CTRL, 32'h3); waitv(32'h80);
    bus(1, `OFS_CTRL, 32'h7); waitv(0);
    bus(1, `OFS_CTRL, 32'h3); waitv(32'h80); bus(1, `OFS_CTRL, 32'h13); waitv(0);
    bus(1, `OFS_CTRL, 0); bus(1, `OFS_CTRL, 32'h100); waitv(32'h40); mv <= 1'b1;
    bus(1, `OFS_CTRL, 32'h108); waitv(0); `CHK(o_prog_stall, 1'b1)
    bus(0, `OFS_STATUS, 0); `CHK(q[4], 1'b1)
    bus(1, `OFS_CTRL, 32'h208); repeat (40) @(posedge i_ref_clk);
    bus(0, `OFS_CMD_VEL, 0); `CHK(q, 32'h0)
    bus(1, `OFS_CTRL, 0); @(posedge i_ref_clk); `CHK(o_prog_stall, 1'b0)
    mv <= 1'b0;
    bus(1, `OFS_TIMEBASE, 32'h1); bus(1, `OFS_CTRL, 32'h100); repeat (60) @(posedge i_ref_clk);
    bus(0, `OFS_CMD_VEL, 0); `CHK(q, 32'h0)
    tick_en <= 1'b1; waitv(32'h40); bus(1, `OFS_CTRL, 0); waitv(0);
    tick_en <= 1'b0;
    bus(1, `OFS_CTRL, 32'h100); repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b0; repeat (4) @(posedge i_ref_clk); i_resetn <= 1'b1;
    bus(0, `OFS_TIMEBASE, 0); `CHK(q, 32'h0)
    stop_test;
  end
endmodule
bind dual_jog_profile_controller jog_chk #(.VW(VW)) u_chk (.i_ref_clk, .i_resetn, .i_address,
  .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_sync_tick,
  .i_prog_move_req, .o_prog_stall, .o_cmd_vel);
`default_nettype wire
